/* logic/rbm_ctrl.v */
`timescale 1ns/1ps
`default_nettype none

// Backup-mode controller with Avalon-MM register access
module rbm_ctrl (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        backup_por_n,
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        main_supply_ok,
  input  wire        watchdog_irq,
  input  wire        low_voltage_irq,
  input  wire        stop_active,
  input  wire        irq_accept,
  output wire        ultra_low_osc_select,
  output wire        backup_allow,
  output wire        pre_backup_request,
  output wire        pre_backup_armed,
  output wire        backup_mode,
  output wire        core_power_off,
  output wire        rtc_clock_divided,
  output wire        rtc_irq_enable,
  output wire        rtc_pin_enable,
  output wire        rtc_trim_enable,
  output reg         stop_release,
  output wire        low_voltage_pending
);

`include "rbm_map.vh"

  // ==========================================================
  // Declarations
  reg        ack_reg;
  reg  [7:0] ctrl_reg;
  reg  [7:0] ctrl_next;
  reg  [7:0] osc_reg;
  reg  [7:0] osc_next;
  reg        armed_reg;
  reg        armed_next;
  reg        backup_reg;
  reg        prot_err_reg;
  reg        lvi_pend_reg;
  reg        lvi_prev_reg;
  reg [31:0] rdata_next;

  wire       wr_go;
  wire       lane0;
  wire       hit_ctrl;
  wire       hit_osc;
  wire       hit_key;
  wire       hit_status;
  wire       hit_bitop;
  wire       bitop_ctrl;
  wire       bitop_osc;
  wire       prot_wr;
  wire       grant;
  wire       fail;
  wire [7:0] bit_mask;
  wire [7:0] bit_fill;
  wire       lvi_rise;
  wire       wdt_exit;

  // ==========================================================
  // Bus handshake
  // Every access answers on the second edge: the first edge loads
  // read data, the second sees waitrequest low and completes.
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_go       = write & ack_reg;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  // Address decode; all registers but the bit-operation port live in byte lane 0
  assign lane0      = byteenable[0];
  assign hit_ctrl   = (address == `RBM_ADDR_CTRL);
  assign hit_osc    = (address == `RBM_ADDR_OSC);
  assign hit_key    = (address == `RBM_ADDR_KEY);
  assign hit_status = (address == `RBM_ADDR_STATUS);
  assign hit_bitop  = (address == `RBM_ADDR_BITOP);

  // Single-bit access goes through the bit-operation port
  assign bitop_ctrl = hit_bitop & ~writedata[`RBM_BITOP_TARGET];
  assign bitop_osc  = hit_bitop & writedata[`RBM_BITOP_TARGET];
  assign bit_mask   = writedata[7:0];
  assign bit_fill   = writedata[`RBM_BITOP_VALUE] ? 8'hff : 8'h00;

  // A protected write is any store that would change a backup register
  assign prot_wr = wr_go & ((lane0 & (hit_ctrl | hit_osc)) | hit_bitop);

  // ==========================================================
  // Write unlock gate
  rbm_protect u_protect (
    .clk      (clk),
    .reset_n  (reset_n),
    .key_wr   (wr_go & lane0 & hit_key),
    .key_data (writedata[7:0]),
    .any_wr   (wr_go),
    .prot_wr  (prot_wr),
    .grant    (grant),
    .fail     (fail)
  );

  // ==========================================================
  // Next values of the backup registers
  // Only the defined bits (two in control, one in oscillator) are stored,
  // so the upper bits cannot be set by a careless write and always read back as zero.
  always @* begin
    ctrl_next = ctrl_reg;
    osc_next  = osc_reg;
    if (grant) begin
      if (hit_ctrl) begin
        ctrl_next = writedata[7:0] & 8'h03;
      end else if (hit_osc) begin
        osc_next = writedata[7:0] & 8'h01;
      end else if (bitop_ctrl) begin
        ctrl_next = ((ctrl_reg & ~bit_mask) | (bit_fill & bit_mask)) & 8'h03;
      end else if (bitop_osc) begin
        osc_next = ((osc_reg & ~bit_mask) | (bit_fill & bit_mask)) & 8'h01;
      end
    end
  end

  // ==========================================================
  // Pre-backup state
  // Arming happens only on a granted write that leaves both allow and
  // request set; a stored request written while allow was clear does
  // not arm later by itself, and a reset before that write cannot arm.
  assign wdt_exit = watchdog_irq & main_supply_ok & armed_reg;

  always @* begin
    armed_next = armed_reg;
    if (wdt_exit) begin
      armed_next = 1'b0;
    end else if (~osc_next[`RBM_OSC_ULTRA] & ~ctrl_next[`RBM_CTRL_REQUEST]) begin
      armed_next = 1'b0;
    end else if (grant & (hit_ctrl | bitop_ctrl) &
                 ctrl_next[`RBM_CTRL_ALLOW] & ctrl_next[`RBM_CTRL_REQUEST]) begin
      armed_next = 1'b1;
    end
  end

  // ==========================================================
  // Backup-domain registers
  // Cleared only by the backup supply power-on reset; the system
  // reset does not reach them, so settings survive every other reset.
  always @(posedge clk or negedge backup_por_n) begin
    if (!backup_por_n) begin
      ctrl_reg   <= `RBM_CTRL_RESET;
      osc_reg    <= `RBM_OSC_RESET;
      armed_reg  <= 1'b0;
      backup_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      osc_reg    <= osc_next;
      armed_reg  <= armed_next;
      // Supply loss while armed drops into backup mode
      if (armed_reg & ~main_supply_ok) begin
        backup_reg <= 1'b1;
      end else if (main_supply_ok) begin
        backup_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Low-voltage recovery and stop release
  // The recovery interrupt wakes the core from stop while pre-backup is armed
  // and not in backup mode, and is held pending until the core accepts it after leaving the old handler.
  assign lvi_rise = low_voltage_irq & ~lvi_prev_reg;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvi_prev_reg <= 1'b0;
      lvi_pend_reg <= 1'b0;
      stop_release <= 1'b0;
    end else begin
      lvi_prev_reg <= low_voltage_irq;
      stop_release <= lvi_rise & stop_active & armed_reg & ~backup_reg;
      // Set wins over acceptance in the same cycle
      if (lvi_rise) begin
        lvi_pend_reg <= 1'b1;
      end else if (irq_accept) begin
        lvi_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Refused protected write flag, write one to clear
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_err_reg <= 1'b0;
    end else if (fail) begin
      prot_err_reg <= 1'b1;
    end else if (wr_go & lane0 & hit_status & writedata[`RBM_ST_PROT_ERR]) begin
      prot_err_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Read data
  // Loaded at the first edge and held while the master waits;
  // unmapped addresses read zero and ignore writes.
  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_next = {24'h00_0000, ctrl_reg};
    end else if (hit_osc) begin
      rdata_next = {24'h00_0000, osc_reg};
    end else if (hit_status) begin
      rdata_next[`RBM_ST_ARMED]    = armed_reg;
      rdata_next[`RBM_ST_BACKUP]   = backup_reg;
      rdata_next[`RBM_ST_PROT_ERR] = prot_err_reg;
      rdata_next[`RBM_ST_LVI_PEND] = lvi_pend_reg;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_reg) begin
      readdata <= rdata_next;
    end
  end

  // ==========================================================
  // Outputs toward oscillator, power switch and RTC
  assign ultra_low_osc_select = osc_reg[`RBM_OSC_ULTRA];
  assign backup_allow         = ctrl_reg[`RBM_CTRL_ALLOW];
  assign pre_backup_request   = ctrl_reg[`RBM_CTRL_REQUEST];
  assign pre_backup_armed     = armed_reg;
  assign backup_mode          = backup_reg;
  // Only RTC and subclock stay alive in backup mode
  assign core_power_off       = backup_reg;
  // Request bit alone retunes the RTC, armed or not
  assign rtc_clock_divided    = ctrl_reg[`RBM_CTRL_REQUEST];
  assign rtc_irq_enable       = ~ctrl_reg[`RBM_CTRL_REQUEST];
  assign rtc_pin_enable       = ~ctrl_reg[`RBM_CTRL_REQUEST];
  assign rtc_trim_enable      = ~ctrl_reg[`RBM_CTRL_REQUEST];
  assign low_voltage_pending  = lvi_pend_reg;

endmodule

`default_nettype wire

/* logic/rbm_map.vh */
// Overview of operation
// - Oscillator mode clears on backup power-on
// - Bit0 selects normal or ultra-low oscillation
// - Only protected-sequence writes change oscillator mode
// - Byte and single-bit read and write access
// - Allow and request set arm pre-backup
// - Ultra-low and request clear exit pre-backup
// - Supply loss while armed enters backup mode
// - Watchdog interrupt while armed exits pre-backup; code exits only while main supply is ok
// - Reset before request set prevents backup mode
// - Supply recovery interrupt releases stop when armed, held
// - Request bit divides RTC clock, stops functions
// - Request without allow stored, not armed
// - Control clears only on backup power-on
`ifndef RBM_MAP_VH
`define RBM_MAP_VH

// ==========================================================
// Register byte addresses
`define RBM_ADDR_CTRL      5'h00
`define RBM_ADDR_OSC       5'h04
`define RBM_ADDR_KEY       5'h08
`define RBM_ADDR_STATUS    5'h0c
`define RBM_ADDR_BITOP     5'h10

// ==========================================================
// Field positions
`define RBM_CTRL_ALLOW     0
`define RBM_CTRL_REQUEST   1
`define RBM_OSC_ULTRA      0
`define RBM_ST_ARMED       0
`define RBM_ST_BACKUP      1
`define RBM_ST_PROT_ERR    2
`define RBM_ST_LVI_PEND    3
`define RBM_BITOP_VALUE    8
`define RBM_BITOP_TARGET   9

// ==========================================================
// Reset values and unlock key
`define RBM_CTRL_RESET     8'h00
`define RBM_OSC_RESET      8'h00
`define RBM_UNLOCK_KEY     8'ha5

`endif

/* logic/rbm_protect.v */
`timescale 1ns/1ps
`default_nettype none

// Unlock gate: one accepted key write opens exactly the next write
module rbm_protect (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       key_wr,
  input  wire [7:0] key_data,
  input  wire       any_wr,
  input  wire       prot_wr,
  output wire       grant,
  output wire       fail
);

`include "rbm_map.vh"

  reg unlocked_reg;
  reg unlocked_next;

  // ==========================================================
  // Unlock state
  // Any write other than the key closes the gate again, so a stray
  // store between key and target cannot leave the block unlocked.
  always @* begin
    unlocked_next = unlocked_reg;
    if (key_wr) begin
      unlocked_next = (key_data == `RBM_UNLOCK_KEY);
    end else if (any_wr) begin
      unlocked_next = 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlocked_reg <= 1'b0;
    end else begin
      unlocked_reg <= unlocked_next;
    end
  end

  // Grant and refusal of protected writes
  assign grant = prot_wr & unlocked_reg;
  assign fail  = prot_wr & ~unlocked_reg;

endmodule

`default_nettype wire

/* testbench/rbm_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Backup controller checker
module rbm_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic backup_por_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic main_supply_ok,
  input wire logic watchdog_irq,
  input wire logic low_voltage_irq,
  input wire logic stop_active,
  input wire logic ultra_low_osc_select,
  input wire logic backup_allow,
  input wire logic pre_backup_request,
  input wire logic pre_backup_armed,
  input wire logic backup_mode,
  input wire logic rtc_clock_divided,
  input wire logic rtc_irq_enable,
  input wire logic stop_release,
  input wire logic low_voltage_pending
);
  // Either reset makes the backup state meaningless to judge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !backup_por_n);

  property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("no answer after one wait cycle");
  property p_rtc; rtc_clock_divided == pre_backup_request && rtc_irq_enable != pre_backup_request;
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc controls not tied to request");
  property p_arm; $rose(pre_backup_armed) |-> backup_allow && pre_backup_request; endproperty
  a_arm: assert property (p_arm) else $error("armed without allow and request");
  property p_exit; !ultra_low_osc_select && !pre_backup_request |-> !pre_backup_armed; endproperty
  a_exit: assert property (p_exit) else $error("armed with exit condition met");
  property p_wdt; pre_backup_armed && watchdog_irq && main_supply_ok |=> !pre_backup_armed;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not disarm");
  property p_enter; pre_backup_armed && !main_supply_ok |=> backup_mode; endproperty
  a_enter: assert property (p_enter) else $error("supply loss did not enter backup");
  property p_leave; backup_mode && main_supply_ok |=> !backup_mode; endproperty
  a_leave: assert property (p_leave) else $error("backup mode held with supply");
  property p_stop;
    $rose(low_voltage_irq) && stop_active && pre_backup_armed && !backup_mode |-> ##[1:2] stop_release;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not released on recovery");
  property p_pend; $rose(low_voltage_irq) |-> ##[1:2] low_voltage_pending; endproperty
  a_pend: assert property (p_pend) else $error("recovery interrupt not held");
  // Main scenarios reached
  c_backup: cover property (pre_backup_armed ##1 backup_mode);
  c_release: cover property ($rose(stop_release));
  c_disarm: cover property ($fell(pre_backup_armed));
endmodule
bind rbm_ctrl rbm_chk u_chk (.*);
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Backup controller bench
module tb_top;
  logic clk, reset_n, backup_por_n, read, write, main_supply_ok, watchdog_irq;
  logic low_voltage_irq, stop_active, irq_accept, waitrequest, ultra_low_osc_select;
  logic backup_allow, pre_backup_request, pre_backup_armed, backup_mode, core_power_off;
  logic rtc_clock_divided, rtc_irq_enable, rtc_pin_enable, rtc_trim_enable, stop_release;
  logic low_voltage_pending, exp_osc;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, q, d;
  int          failures, n_checks, i;

  rbm_ctrl dut (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] osc_of(input logic b);
    return {31'h0, b};
  endfunction
  function automatic logic [31:0] bitop(input logic tgt, input logic v, input logic [7:0] m);
    return {22'h0, tgt, v, m};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Request held until waitrequest is seen low; one idle cycle follows
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= dat;
    write <= wr;
    read <= !wr;
    // Waitrequest and read data are seen as they stand at the edge
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // Key write opens exactly the following write
  task automatic pw(input logic [4:0] a, input logic [31:0] dat);
    bus(1'b1, 5'h08, 32'ha5);
    bus(1'b1, a, dat);
  endtask
  task automatic pulse_rst;
    @(posedge clk);
    reset_n <= 1'b0;
    tick(2);
    @(posedge clk);
    reset_n <= 1'b1;
    tick(1);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(52));
    {reset_n, backup_por_n, read, write, watchdog_irq, low_voltage_irq} = '0;
    {stop_active, irq_accept, address, writedata} = '0;
    main_supply_ok = 1'b1;
    byteenable = 4'hf;
    failures = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    backup_por_n <= 1'b1;
    tick(1);
    // Bench runs on the main clock throughout
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h0);
    bus(1'b1, 5'h04, 32'h1);
    rd(5'h04, 32'h0);
    rd(5'h0c, 32'h4);
    bus(1'b1, 5'h0c, 32'h4);
    pw(5'h04, 32'hff);
    rd(5'h04, 32'h1);
    check(ultra_low_osc_select, 32'h1);
    pw(5'h04, 32'h0);
    pw(5'h00, 32'h2);
    rd(5'h00, 32'h2);
    check(pre_backup_armed, 32'h0);
    check({rtc_clock_divided, rtc_irq_enable, rtc_pin_enable, rtc_trim_enable}, 32'h8);
    pw(5'h00, 32'h1);
    pw(5'h00, 32'h3);
    check(pre_backup_armed, 32'h1);
    pw(5'h10, bitop(1'b1, 1'b1, 8'h01));
    pulse_rst();
    rd(5'h04, 32'h1);
    rd(5'h00, 32'h3);
    check(pre_backup_armed, 32'h1);
    @(posedge clk);
    watchdog_irq <= 1'b1;
    @(posedge clk);
    watchdog_irq <= 1'b0;
    tick(1);
    check(pre_backup_armed, 32'h0);
    pw(5'h10, bitop(1'b0, 1'b0, 8'h02));
    rd(5'h00, 32'h1);
    pw(5'h10, bitop(1'b0, 1'b1, 8'h02));
    check(pre_backup_armed, 32'h1);
    @(posedge clk);
    main_supply_ok <= 1'b0;
    tick(2);
    check({backup_mode, core_power_off}, 32'h3);
    @(posedge clk);
    main_supply_ok <= 1'b1;
    tick(2);
    check(backup_mode, 32'h0);
    // Supply comes back while the core sleeps
    @(posedge clk);
    stop_active <= 1'b1;
    low_voltage_irq <= 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (stop_release !== 1'b1 && i < 4);
    check(stop_release, 32'h1);
    tick(1);
    check({stop_release, low_voltage_pending}, 32'h1);
    @(posedge clk);
    irq_accept <= 1'b1;
    @(posedge clk);
    irq_accept <= 1'b0;
    low_voltage_irq <= 1'b0;
    stop_active <= 1'b0;
    tick(1);
    check(low_voltage_pending, 32'h0);
    pw(5'h04, 32'h0);
    check(pre_backup_armed, 32'h1);
    pw(5'h00, 32'h1);
    check(pre_backup_armed, 32'h0);
    pulse_rst();
    @(posedge clk);
    main_supply_ok <= 1'b0;
    tick(3);
    check(backup_mode, 32'h0);
    @(posedge clk);
    main_supply_ok <= 1'b1;
    rd(5'h14, 32'h0);
    // Random mix of unlocked and bare writes
    exp_osc = 1'b0;
    for (i = 0; i < 24; i++) begin
      d = $urandom;
      if (d[31]) pw(5'h04, osc_of(d[0]));
      else bus(1'b1, 5'h04, osc_of(d[0]));
      if (d[31]) exp_osc = d[0];
      rd(5'h04, osc_of(exp_osc));
    end
    @(posedge clk);
    backup_por_n <= 1'b0;
    tick(1);
    @(posedge clk);
    backup_por_n <= 1'b1;
    tick(1);
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
